/* src/urg_bank.sv */
// Purpose: divisor latches, modem line status and pin direction bank
// Assumes: host serial bus already decoded into byte writes and reads
// Notes: por_n is power-up only; rst_n is the external reset pin
//
// Operation
// - direction bit zero drives pin as output
// - direction bit one means input; resets 0xFF
// - power-up loads divisor high 0x00, low 0x01
// - reset pin leaves divisor bytes untouched
// - status low nibble cleared, high nibble inverted inputs
`timescale 1ns/1ps
module urg_bank
  import urg_pkg::*;
#(
  parameter int NUM_BANKS = 2
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // baud divisors
  output logic [15:0] tx_divisor,
  output logic [15:0] rx_divisor,
  // modem inputs, active level as seen on the pins
  input wire logic [3:0] modem_in,
  // general-purpose pins
  input wire logic [8*NUM_BANKS-1:0] gpio_in,
  output logic [8*NUM_BANKS-1:0] gpio_out,
  output logic [8*NUM_BANKS-1:0] gpio_oe
);
  // =====================================================================
  // decode
  localparam int BANK_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
  logic [BANK_W-1:0] bank_select;
  logic [7:0] div_tx_low;
  logic [7:0] div_tx_high;
  logic [7:0] div_rx_low;
  logic [7:0] div_rx_high;
  logic [7:0] pin_direction_select [NUM_BANKS];
  logic [7:0] pin_level [NUM_BANKS];
  logic [3:0] modem_sync1;
  logic [3:0] modem_sync2;
  logic [3:0] modem_prev;
  logic [3:0] modem_delta;
  logic [8*NUM_BANKS-1:0] gpio_sync1;
  logic [8*NUM_BANKS-1:0] gpio_sync2;
  logic [7:0] modem_line_status;
  logic [7:0] next_rdata;
  logic status_read;
  logic wr_div_tx_low;
  logic wr_div_tx_high;
  logic wr_div_rx_low;
  logic wr_div_rx_high;
  logic wr_pin_level;
  logic wr_pin_direction;
  logic wr_bank_select;
  logic [1:0] modem_settle;
  logic modem_ready;
  logic [3:0] modem_change;

  // =====================================================================
  // write strobes
  // each index names one register, so at most one strobe rises per cycle
  assign wr_div_tx_low = reg_wr && (reg_addr == OFF_DIV_TX_LOW);
  assign wr_div_tx_high = reg_wr && (reg_addr == OFF_DIV_TX_HIGH);
  assign wr_div_rx_low = reg_wr && (reg_addr == OFF_DIV_RX_LOW);
  assign wr_div_rx_high = reg_wr && (reg_addr == OFF_DIV_RX_HIGH);
  assign wr_pin_level = reg_wr && (reg_addr == OFF_PIN_LEVEL);
  assign wr_pin_direction = reg_wr && (reg_addr == OFF_PIN_DIRECTION);
  assign wr_bank_select = reg_wr && (reg_addr == OFF_BANK_SELECT);
  // status has no write strobe; reading it clears the change flags
  assign status_read = reg_rd && (reg_addr == OFF_MODEM_STATUS);

  // =====================================================================
  // divisor latches
  // only power-up resets these so a pin reset keeps the programmed baud rate
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      div_tx_low <= RST_DIV_LOW;
      div_tx_high <= RST_DIV_HIGH;
    end else begin
      if (wr_div_tx_low) begin
        div_tx_low <= reg_wdata;
      end
      if (wr_div_tx_high) begin
        div_tx_high <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      div_rx_low <= RST_DIV_LOW;
      div_rx_high <= RST_DIV_HIGH;
    end else begin
      if (wr_div_rx_low) begin
        div_rx_low <= reg_wdata;
      end
      if (wr_div_rx_high) begin
        div_rx_high <= reg_wdata;
      end
    end
  end

  assign tx_divisor = {div_tx_high, div_tx_low};
  assign rx_divisor = {div_rx_high, div_rx_low};

  // =====================================================================
  // bank select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select <= '0;
    end else if (wr_bank_select) begin
      bank_select <= reg_wdata[BANK_W-1:0];
    end
  end

  // =====================================================================
  // pin banks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_sync1 <= '0;
      gpio_sync2 <= '0;
    end else begin
      gpio_sync1 <= gpio_in;
      gpio_sync2 <= gpio_sync1;
    end
  end

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_direction_select[b] <= RST_PIN_DIRECTION;
        pin_level[b] <= RST_PIN_LEVEL;
      end else if (bank_select == BANK_W'(b)) begin
        if (wr_pin_direction) begin
          pin_direction_select[b] <= reg_wdata;
        end
        if (wr_pin_level) begin
          pin_level[b] <= reg_wdata;
        end
      end
    end
    assign gpio_oe[8*b +: 8] = ~pin_direction_select[b];
    assign gpio_out[8*b +: 8] = pin_level[b];
  end

  // =====================================================================
  // modem line status
  // sync resets to zero, so the level nibble reads ones for two cycles after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_sync1 <= '0;
      modem_sync2 <= '0;
    end else begin
      modem_sync1 <= modem_in;
      modem_sync2 <= modem_sync1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_prev <= '0;
    end else begin
      modem_prev <= modem_sync2;
    end
  end

  // zeroed sync flops would look like a change after reset,
  // so edges only count once the history holds real samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_settle <= '0;
    end else if (!modem_ready) begin
      modem_settle <= modem_settle + 2'h1;
    end
  end

  assign modem_ready = (modem_settle == MODEM_SETTLE);
  assign modem_change = modem_ready ? (modem_sync2 ^ modem_prev) : 4'h0;

  // change flags: a change in the read cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_delta <= RST_MODEM_DELTA;
    end else begin
      modem_delta <= (status_read ? RST_MODEM_DELTA : modem_delta) | modem_change;
    end
  end

  assign modem_line_status[MODEM_LEVEL_LSB +: 4] = ~modem_sync2;
  assign modem_line_status[MODEM_DELTA_LSB +: 4] = modem_delta;

  // =====================================================================
  // read data
  always_comb begin
    next_rdata = RST_BYTE;
    case (reg_addr)
      OFF_DIV_TX_LOW: next_rdata = div_tx_low;
      OFF_DIV_TX_HIGH: next_rdata = div_tx_high;
      OFF_DIV_RX_LOW: next_rdata = div_rx_low;
      OFF_DIV_RX_HIGH: next_rdata = div_rx_high;
      OFF_MODEM_STATUS: next_rdata = modem_line_status;
      OFF_PIN_LEVEL: next_rdata = gpio_sync2[8*bank_select +: 8];
      OFF_PIN_DIRECTION: next_rdata = pin_direction_select[bank_select];
      OFF_BANK_SELECT: next_rdata = 8'(bank_select);
      default: next_rdata = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : urg_bank

/* common/urg_pkg.sv */
// Purpose: shared constants for the uart reset-state and pin direction bank
// Assumes: 8-bit register port, 4-bit register index
// Notes: offsets index the local register port
package urg_pkg;
  // =====================================================================
  // register offsets
  localparam logic [3:0] OFF_DIV_TX_LOW = 4'h0;
  localparam logic [3:0] OFF_DIV_TX_HIGH = 4'h1;
  localparam logic [3:0] OFF_DIV_RX_LOW = 4'h2;
  localparam logic [3:0] OFF_DIV_RX_HIGH = 4'h3;
  localparam logic [3:0] OFF_MODEM_STATUS = 4'h4;
  localparam logic [3:0] OFF_PIN_LEVEL = 4'h5;
  localparam logic [3:0] OFF_PIN_DIRECTION = 4'h6;
  localparam logic [3:0] OFF_BANK_SELECT = 4'h7;
  // =====================================================================
  // reset values
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PIN_LEVEL = 8'h00;
  localparam logic [3:0] RST_MODEM_DELTA = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // =====================================================================
  // field layout of the modem status register
  localparam int MODEM_LEVEL_LSB = 4;
  localparam int MODEM_DELTA_LSB = 0;
  // =====================================================================
  // timing
  localparam logic [1:0] MODEM_SETTLE = 2'h3;
endpackage : urg_pkg

/* sim/urg_bank_assertions.sv */
// Purpose: port checks for the reset-state and pin direction bank
// Assumes: writes only while both resets are high
// Notes: divisor checks use the power-up reset as disable
`timescale 1ns/1ps
module urg_chk
  import urg_pkg::*;
#(
  parameter int NUM_BANKS = 2
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // outputs and the modem inputs
  input wire logic [15:0] tx_divisor,
  input wire logic [15:0] rx_divisor,
  input wire logic [3:0] modem_in,
  input wire logic [8*NUM_BANKS-1:0] gpio_out,
  input wire logic [8*NUM_BANKS-1:0] gpio_oe
);
  // ==========================================================
  // helpers
  localparam int BANK_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
  logic [BANK_W-1:0] bank_seen;
  // bank index as software last wrote it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_seen <= '0;
    end else if (reg_wr && reg_addr == OFF_BANK_SELECT) begin
      bank_seen <= reg_wdata[BANK_W-1:0];
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_after_reset: assert property ($rose(rst_n) |-> gpio_oe == '0) else $error("oe not idle");
  a_dir_write_oe: assert property (reg_wr && reg_addr == OFF_PIN_DIRECTION |=>
    gpio_oe[8*bank_seen +: 8] == ~$past(reg_wdata)) else $error("oe mismatch");
  a_level_write: assert property (reg_wr && reg_addr == OFF_PIN_LEVEL |=>
    gpio_out[8*bank_seen +: 8] == $past(reg_wdata)) else $error("level mismatch");
  a_oe_holds: assert property (!(reg_wr && reg_addr == OFF_PIN_DIRECTION) |=> $stable(gpio_oe))
    else $error("oe moved");
  a_div_powerup: assert property (disable iff (!por_n) $rose(por_n) |->
    tx_divisor == 16'h0001 && rx_divisor == 16'h0001) else $error("bad divisor default");
  a_div_keep: assert property (disable iff (!por_n) !rst_n && !$past(reg_wr) |->
    $stable(tx_divisor) && $stable(rx_divisor)) else $error("divisor lost on reset");
  a_modem_level: assert property (reg_rd && reg_addr == OFF_MODEM_STATUS && $past(rst_n) && $past(rst_n, 2) &&
    $stable(modem_in) && modem_in == $past(modem_in, 2) |=> reg_rdata[7:4] == ~$past(modem_in))
    else $error("bad level nibble");
  // ==========================================================
  // covers
  c_status_read: cover property (reg_rd && reg_addr == OFF_MODEM_STATUS);
  c_bank_sel: cover property (reg_wr && reg_addr == OFF_BANK_SELECT);
  c_dir_write: cover property (reg_wr && reg_addr == OFF_PIN_DIRECTION);
  c_reset_out: cover property ($rose(rst_n));
endmodule : urg_chk
bind urg_bank urg_chk #(.NUM_BANKS(NUM_BANKS)) chk_u (.clk, .rst_n, .por_n, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .tx_divisor, .rx_divisor, .modem_in, .gpio_out, .gpio_oe);

/* sim/tb_urg_bank.sv */
// Purpose: directed register tests for the bank
// Assumes: inputs change on the falling edge
// Notes: wr and rd each end with an idle cycle so no strobe toggles twice at once
`timescale 1ns/1ps
module tb_urg_bank
  import urg_pkg::*;
;
  logic clk = 0, rst_n = 0, por_n = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0, modem_in = 4'hA;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [15:0] tx_divisor, rx_divisor, gpio_out, gpio_oe;
  logic [15:0] gpio_in = 16'h0000;
  int fails = 0, checks_done = 0;
  initial forever #2.5 clk = ~clk;
  urg_bank #(.NUM_BANKS(2)) dut_u (.clk, .rst_n, .por_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .tx_divisor, .rx_divisor, .modem_in, .gpio_in, .gpio_out, .gpio_oe);
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  // mask drops bits that a test does not own
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({8'h00, reg_rdata & m}, {8'h00, e});
    @(negedge clk);
  endtask : rd
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(negedge clk);
    por_n = 1'b1;
    rst_n = 1'b1;
    @(negedge clk);
    chk(tx_divisor, 16'h0001);
    chk(rx_divisor, 16'h0001);
    chk(gpio_oe, 16'h0000);
    rd(OFF_PIN_DIRECTION, 8'hFF, 8'hFF);
    $display("test reset defaults done");
    wr(OFF_DIV_TX_LOW, 8'h34);
    wr(OFF_DIV_TX_HIGH, 8'h12);
    wr(OFF_DIV_RX_LOW, 8'h78);
    wr(OFF_DIV_RX_HIGH, 8'h56);
    wr(OFF_PIN_DIRECTION, 8'h0F);
    chk(gpio_oe, 16'h00F0);
    wr(OFF_BANK_SELECT, 8'h01);
    wr(OFF_PIN_DIRECTION, 8'hAA);
    chk(gpio_oe, 16'h55F0);
    rd(OFF_PIN_DIRECTION, 8'hAA, 8'hFF);
    rd(OFF_MODEM_STATUS, 8'h50, 8'hFF);
    rd(OFF_MODEM_STATUS, 8'h50, 8'hFF);
    wr(OFF_PIN_LEVEL, 8'hC3);
    chk(gpio_out, 16'hC300);
    gpio_in = 16'h5A00;
    repeat (2) @(negedge clk);
    rd(OFF_PIN_LEVEL, 8'h5A, 8'hFF);
    modem_in = 4'h3;
    repeat (4) @(negedge clk);
    rd(OFF_MODEM_STATUS, 8'hC9, 8'hFF);
    rd(OFF_MODEM_STATUS, 8'hC0, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    $display("test writes and status done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(tx_divisor, 16'h1234);
    chk(rx_divisor, 16'h5678);
    chk(gpio_oe, 16'h0000);
    rd(OFF_PIN_DIRECTION, 8'hFF, 8'hFF);
    rd(OFF_MODEM_STATUS, 8'hC0, 8'hFF);
    $display("test pin reset done");
    print_verdict();
  end
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
endmodule : tb_urg_bank
